// >>> hdl/isolated_io_channel_port.sv
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "io_port_cfg.svh"
`default_nettype none

module isolated_io_channel_port
    import io_port_pkg::*;
(
    input wire logic clk_i, // 250 MHz clock
    input wire logic reset_i, // synchronous, active high
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb enable
    input wire logic pwrite_i, // apb direction
    input wire logic [7:0] paddr_i, // apb byte address
    input wire logic [31:0] pwdata_i, // apb write data
    output logic [31:0] prdata_o, // apb read data
    output logic pready_o, // apb ready
    output logic pslverr_o, // apb error
    input wire logic [7:0] channel_in_i, // channel sense pins
    output logic [7:0] channel_out_o, // channel drive latch
    output logic irq_pin_o, // interrupt pin level when driven
    output logic irq_oe_n_o, // low while pulling interrupt low
    output logic [3:0] flag_pin_o, // flag pin levels when driven
    output logic [3:0] flag_oe_n_o // low while pulling a flag low
);

    // ----------------------------------------------------------------
    // change detection
    // ----------------------------------------------------------------
    function automatic logic [7:0] change_req(input logic [7:0] present,
                                              input logic [7:0] captured,
                                              input detect_mode_t mode);
        logic [7:0] r;
        r = 8'h00;
        unique case (mode)
            DETECT_BOTH: r = present ^ captured;
            DETECT_ON_TO_OFF: r = captured & ~present;
            DETECT_OFF_TO_ON: r = present & ~captured;
            DETECT_NONE: r = 8'h00;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] in_meta_q;
    logic [7:0] in_sync_q;
    logic [7:0] out_q;
    logic [7:0] out_d;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic [7:0] capture_q;
    logic [7:0] capture_d;
    logic [`CFG_WIDTH-1:0] cfg_q;
    logic [`CFG_WIDTH-1:0] cfg_d;
    logic selected_q;
    logic selected_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire setup_phase = psel_i & ~penable_i;
    wire access_wr = psel_i & penable_i & pwrite_i;
    wire setup_rd = setup_phase & ~pwrite_i;
    wire hit_sel = (paddr_i == `OFS_GROUP_SELECT);
    wire hit_data = (paddr_i == `OFS_CHANNEL_DATA);
    wire hit_mask = (paddr_i == `OFS_IRQ_MASK);
    wire hit_cfg = (paddr_i == `OFS_LINK_CONFIG);
    wire hit_sts = (paddr_i == `OFS_PORT_STATUS);
    wire mapped = hit_sel | hit_data | hit_mask | hit_cfg | hit_sts;

    wire [3:0] group_addr = cfg_q[`CFG_GROUP_MSB:`CFG_GROUP_LSB];
    wire irq_link = cfg_q[`CFG_IRQ_LINK_BIT];
    wire flag_link = cfg_q[`CFG_FLAG_LINK_BIT];
    wire [1:0] flag_sel = cfg_q[`CFG_FLAG_SEL_MSB:`CFG_FLAG_SEL_LSB];
    wire detect_mode_t detect_mode = detect_mode_t'(cfg_q[`CFG_DETECT_MSB:`CFG_DETECT_LSB]);

    // written ones override inputs; output channels read back their latch
    wire [7:0] present = in_sync_q | out_q;
    wire [7:0] req = change_req(present, capture_q, detect_mode);
    wire irq_active = |(req & mask_q);

    wire sel_wr = access_wr & hit_sel;
    wire sel_match = (pwdata_i[`SEL_GROUP_MSB:`SEL_GROUP_LSB] == group_addr);
    wire data_wr = access_wr & hit_data & selected_q;
    wire mask_wr = access_wr & hit_mask & selected_q;
    wire cfg_wr = access_wr & hit_cfg;
    wire data_rd = setup_rd & hit_data & selected_q;

    wire [31:0] status_word = {16'h0000, req, 6'h00, irq_active, selected_q};

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    assign selected_d = sel_wr ? sel_match : selected_q;
    assign out_d = data_wr ? pwdata_i[7:0] : out_q;
    assign mask_d = mask_wr ? pwdata_i[7:0] : mask_q;
    assign cfg_d = cfg_wr ? pwdata_i[`CFG_WIDTH-1:0] : cfg_q;
    assign capture_d = data_rd ? present : capture_q;
    assign rdata_d = ~setup_rd ? rdata_q :
                     data_rd ? {24'h000000, present} :
                     hit_mask ? {24'h000000, mask_q} :
                     hit_cfg ? {{(32 - `CFG_WIDTH){1'b0}}, cfg_q} :
                     hit_sts ? status_word :
                     32'h00000000;

    // ----------------------------------------------------------------
    // input synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            in_meta_q <= 8'h00;
            in_sync_q <= 8'h00;
        end else begin
            in_meta_q <= channel_in_i;
            in_sync_q <= in_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            out_q <= `RST_OUTPUTS;
        end else begin
            out_q <= out_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mask_q <= `RST_MASK;
        end else begin
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            capture_q <= `RST_CAPTURE;
        end else begin
            capture_q <= capture_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_q <= `RST_LINK_CONFIG;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            selected_q <= (`RST_GROUP == 4'h0);
        end else begin
            selected_q <= selected_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_q <= `RST_RDATA;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;
    assign prdata_o = rdata_q;
    assign channel_out_o = out_q;
    assign irq_pin_o = 1'b0;
    assign irq_oe_n_o = ~(irq_active & irq_link);

    genvar f;
    generate
        for (f = 0; f < 4; f++) begin : g_flag
            assign flag_pin_o[f] = 1'b0;
            assign flag_oe_n_o[f] = ~(irq_active & flag_link & selected_q
                                      & (flag_sel == 2'(f)));
        end
    endgenerate

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_reset_clears_out: assert property (@(posedge clk_i)
        $past(reset_i) |-> (channel_out_o == 8'h00 && mask_q == 8'h00))
        else $error("reset did not clear outputs and mask");

    a_select_by_nibble: assert property (@(posedge clk_i) disable iff (reset_i)
        $past(sel_wr) |-> (selected_q ==
            ($past(pwdata_i[7:4]) == $past(group_addr))))
        else $error("selection does not follow select write nibble");

    a_reset_autoselect: assert property (@(posedge clk_i)
        $past(reset_i) |-> (selected_q == (`RST_GROUP == 4'h0)))
        else $error("selection after reset wrong");

    a_output_write: assert property (@(posedge clk_i) disable iff (reset_i)
        (access_wr && hit_data && selected_q) |=> (channel_out_o == $past(pwdata_i[7:0])))
        else $error("output channels not updated by data write");

    a_output_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        !(access_wr && hit_data && selected_q) |=> $stable(channel_out_o))
        else $error("output channels changed without a selected write");

    a_read_capture: assert property (@(posedge clk_i) disable iff (reset_i)
        (setup_rd && hit_data && selected_q) |=>
            (prdata_o[7:0] == capture_q && capture_q == $past(present)))
        else $error("read data differs from capture latch");

    a_mask_load: assert property (@(posedge clk_i) disable iff (reset_i)
        (access_wr && hit_mask && !selected_q) |=> $stable(mask_q))
        else $error("mask loaded while not selected");

    a_irq_gating: assert property (@(posedge clk_i) disable iff (reset_i)
        !irq_oe_n_o |-> (irq_link && |(req & mask_q)))
        else $error("interrupt driven without link or enabled request");

    a_irq_persists: assert property (@(posedge clk_i) disable iff (reset_i)
        (irq_active && !data_rd && !mask_wr && !cfg_wr) |=>
            (irq_active || $changed(present)))
        else $error("interrupt dropped without reread or channel return");

    a_flag_selected: assert property (@(posedge clk_i) disable iff (reset_i)
        (flag_oe_n_o != 4'hF) |-> (selected_q && irq_active))
        else $error("flag line driven while not selected");

    a_select_match: assert property (@(posedge clk_i) disable iff (reset_i)
        (sel_wr && pwdata_i[`SEL_GROUP_MSB:`SEL_GROUP_LSB] == group_addr) |=> selected_q)
        else $error("matching select write did not select the board");

    a_select_miss: assert property (@(posedge clk_i) disable iff (reset_i)
        (sel_wr && pwdata_i[`SEL_GROUP_MSB:`SEL_GROUP_LSB] != group_addr) |=> !selected_q)
        else $error("foreign select write left the board selected");

    a_select_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        !sel_wr |=> $stable(selected_q))
        else $error("selection changed without a select write");

    a_mask_write: assert property (@(posedge clk_i) disable iff (reset_i)
        (access_wr && hit_mask && selected_q) |=> (mask_q == $past(pwdata_i[7:0])))
        else $error("mask not loaded by a selected mask write");

    a_mask_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        !(access_wr && hit_mask && selected_q) |=> $stable(mask_q))
        else $error("mask changed without a selected mask write");

    a_read_all_chan: assert property (@(posedge clk_i) disable iff (reset_i)
        (setup_rd && hit_data && selected_q) |=>
            (prdata_o[7:0] == ($past(in_sync_q) | $past(channel_out_o))
             && prdata_o[31:8] == 24'h000000))
        else $error("channel read differs from inputs and output latch");

    a_read_unsel: assert property (@(posedge clk_i) disable iff (reset_i)
        (setup_rd && hit_data && !selected_q) |=> (prdata_o == 32'h00000000))
        else $error("unselected channel read returned data");

    a_capture_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        !(setup_rd && hit_data && selected_q) |=> $stable(capture_q))
        else $error("capture latch changed outside a selected read");

    a_req_equal: assert property (@(posedge clk_i) disable iff (reset_i)
        (present == capture_q) |-> (req == 8'h00))
        else $error("change request without a difference");

    a_req_both: assert property (@(posedge clk_i) disable iff (reset_i)
        (detect_mode == DETECT_BOTH && present != capture_q) |-> (req != 8'h00))
        else $error("difference raised no change request");

    a_req_on_off: assert property (@(posedge clk_i) disable iff (reset_i)
        (detect_mode == DETECT_ON_TO_OFF) |-> ((req & present) == 8'h00))
        else $error("on to off mode raised a request for an on channel");

    a_req_off_on: assert property (@(posedge clk_i) disable iff (reset_i)
        (detect_mode == DETECT_OFF_TO_ON) |-> ((req & ~present) == 8'h00))
        else $error("off to on mode raised a request for an off channel");

    a_irq_unselected: assert property (@(posedge clk_i) disable iff (reset_i)
        (irq_link && (req & mask_q) != 8'h00) |-> !irq_oe_n_o)
        else $error("enabled change request did not drive the interrupt");

    a_irq_link_off: assert property (@(posedge clk_i) disable iff (reset_i)
        !irq_link |-> irq_oe_n_o)
        else $error("interrupt driven with the link removed");

    a_mask_keeps_req: assert property (@(posedge clk_i) disable iff (reset_i)
        mask_wr |=> $stable(capture_q))
        else $error("mask write disturbed the change request");

    a_pins_low: assert property (@(posedge clk_i) disable iff (reset_i)
        (irq_pin_o == 1'b0 && flag_pin_o == 4'h0))
        else $error("open drain pin level is not low");

    a_flag_one_line: assert property (@(posedge clk_i) disable iff (reset_i)
        $onehot0(~flag_oe_n_o))
        else $error("more than one flag line driven");

    a_flag_mirror: assert property (@(posedge clk_i) disable iff (reset_i)
        (irq_active && flag_link && selected_q) |-> !flag_oe_n_o[flag_sel])
        else $error("chosen flag line does not mirror the interrupt");

    a_sync_two_stage: assert property (@(posedge clk_i) disable iff (reset_i)
        (!$past(reset_i) && !$past(reset_i, 2)) |-> (in_sync_q == $past(channel_in_i, 2)))
        else $error("channel input not delayed by two flip-flops");

    a_status_bits: assert property (@(posedge clk_i) disable iff (reset_i)
        (setup_rd && hit_sts) |=>
            (prdata_o[1] == $past(irq_active) && prdata_o[0] == $past(selected_q)))
        else $error("status read differs from interrupt and selection state");

endmodule

`default_nettype wire

// >>> inc/io_port_cfg.svh
`ifndef IO_PORT_CFG_SVH
`define IO_PORT_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_GROUP_SELECT 8'h00
`define OFS_CHANNEL_DATA 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_LINK_CONFIG 8'h0C
`define OFS_PORT_STATUS 8'h10

// ----------------------------------------------------------------
// group select write field
// ----------------------------------------------------------------
`define SEL_GROUP_MSB 7
`define SEL_GROUP_LSB 4

// ----------------------------------------------------------------
// link config fields
// ----------------------------------------------------------------
`define CFG_GROUP_MSB 3
`define CFG_GROUP_LSB 0
`define CFG_IRQ_LINK_BIT 4
`define CFG_FLAG_LINK_BIT 5
`define CFG_FLAG_SEL_MSB 7
`define CFG_FLAG_SEL_LSB 6
`define CFG_DETECT_MSB 9
`define CFG_DETECT_LSB 8
`define CFG_WIDTH 10

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define STS_SELECTED_BIT 0
`define STS_IRQ_BIT 1
`define STS_REQ_LSB 8
`define STS_REQ_MSB 15

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_OUTPUTS 8'h00
`define RST_MASK 8'h00
`define RST_CAPTURE 8'h00
`define RST_LINK_CONFIG 10'h010
`define RST_GROUP 4'h0
`define RST_RDATA 32'h00000000

`endif

// >>> inc/io_port_pkg.sv
`default_nettype none

package io_port_pkg;

    typedef enum logic [1:0] {
        DETECT_BOTH = 2'h0,
        DETECT_ON_TO_OFF = 2'h1,
        DETECT_OFF_TO_ON = 2'h2,
        DETECT_NONE = 2'h3
    } detect_mode_t;

endpackage

`default_nettype wire

// >>> testbench/host_board_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_board_model (
    input wire logic clk_i, // bus clock
    output logic psel_o, // apb select
    output logic penable_o, // apb enable
    output logic pwrite_o, // apb direction
    output logic [7:0] paddr_o, // apb byte address
    output logic [31:0] pwdata_o, // apb write data
    input wire logic [31:0] prdata_i, // apb read data
    input wire logic pready_i, // apb ready
    input wire logic pslverr_i // apb error
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h00000000;
    end

    // one full apb transfer; request held until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= addr;
        pwdata_o <= wdata;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do
            @(posedge clk_i);
        while (pready_i !== 1'b1);
        rdata = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        pwdata_o <= ~wdata;
    endtask
endmodule

`default_nettype wire

// >>> testbench/test_isolated_io_channel_port.sv
`timescale 1ns/10ps
`include "io_port_cfg.svh"
`default_nettype none

module test_isolated_io_channel_port;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] channel_in_i = 8'h00;
    logic psel, penable, pwrite, pready, pslverr, irq_pin, irq_oe_n;
    logic [7:0] paddr, channel_out;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] flag_pin, flag_oe_n;
    int failures = 0;
    int n_compared = 0;

    always #2 clk_i = ~clk_i;

    host_board_model host_u (.clk_i(clk_i), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
        .pready_i(pready), .pslverr_i(pslverr));

    isolated_io_channel_port dut_u (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .channel_in_i(channel_in_i), .channel_out_o(channel_out), .irq_pin_o(irq_pin),
        .irq_oe_n_o(irq_oe_n), .flag_pin_o(flag_pin), .flag_oe_n_o(flag_oe_n));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        host_u.xfer(1'b1, a, d, q, e);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        logic e;
        host_u.xfer(1'b0, a, 32'h00000000, r, e);
        #1;
    endtask

    // pins pass two sync stages before they count
    task automatic pins(input logic [7:0] v);
        @(posedge clk_i);
        channel_in_i <= v;
        repeat (4) @(posedge clk_i);
        #1;
    endtask

    task automatic irq_is(input logic v);
        chk(32'(irq_oe_n), 32'(v));
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk(32'(channel_out), 32'h00000000);
        chk(32'(flag_oe_n), 32'h0000000F);
        chk(32'(irq_pin), 32'h00000000);
        chk(32'(flag_pin), 32'h00000000);
        irq_is(1'b1);
        rd(`OFS_IRQ_MASK);
        chk(r, 32'h00000000);
        rd(`OFS_PORT_STATUS);
        chk(32'(r[0]), 32'h00000001);
        $display("reset test done");
    endtask

    task automatic t_data;
        pins(8'h05);
        wr(`OFS_CHANNEL_DATA, 32'h00000050);
        chk(32'(channel_out), 32'h00000050);
        wr(`OFS_CHANNEL_DATA, 32'h000000A0);
        chk(32'(channel_out), 32'h000000A0);
        rd(`OFS_CHANNEL_DATA);
        chk(r, 32'h000000A5);
        $display("data test done");
    endtask

    task automatic t_irq;
        wr(`OFS_LINK_CONFIG, 32'h000000B0);
        wr(`OFS_IRQ_MASK, 32'h00000001);
        rd(`OFS_CHANNEL_DATA);
        irq_is(1'b1);
        pins(8'h04);
        irq_is(1'b0);
        chk(32'(flag_oe_n), 32'h0000000B);
        wr(`OFS_LINK_CONFIG, 32'h000000B3);
        wr(`OFS_GROUP_SELECT, 32'h00000020);
        irq_is(1'b0);
        chk(32'(flag_oe_n), 32'h0000000F);
        wr(`OFS_CHANNEL_DATA, 32'h00000000);
        chk(32'(channel_out), 32'h000000A0);
        wr(`OFS_GROUP_SELECT, 32'h0000003C);
        rd(`OFS_PORT_STATUS);
        chk(32'(r[0]), 32'h00000001);
        wr(`OFS_IRQ_MASK, 32'h00000000);
        irq_is(1'b1);
        wr(`OFS_IRQ_MASK, 32'h00000001);
        irq_is(1'b0);
        pins(8'h05);
        irq_is(1'b1);
        pins(8'h04);
        rd(`OFS_CHANNEL_DATA);
        chk(r, 32'h000000A4);
        irq_is(1'b1);
        wr(`OFS_LINK_CONFIG, 32'h000000A3);
        pins(8'h05);
        irq_is(1'b1);
        rd(`OFS_PORT_STATUS);
        chk(32'(r[1]), 32'h00000001);
        $display("interrupt test done");
    endtask

    task automatic t_mode;
        wr(`OFS_LINK_CONFIG, 32'h000001B3);
        rd(`OFS_CHANNEL_DATA);
        pins(8'h04);
        irq_is(1'b0);
        rd(`OFS_CHANNEL_DATA);
        pins(8'h05);
        irq_is(1'b1);
        wr(`OFS_LINK_CONFIG, 32'h000002B3);
        pins(8'h04);
        rd(`OFS_CHANNEL_DATA);
        pins(8'h05);
        irq_is(1'b0);
        $display("detect mode test done");
    endtask

    task automatic t_unmapped;
        logic e;
        host_u.xfer(1'b0, 8'h14, 32'h00000000, r, e);
        chk(32'(e), 32'h00000001);
        chk(r, 32'h00000000);
        $display("unmapped test done");
    endtask

    task automatic tally_and_finish;
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        tally_and_finish();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        t_reset();
        t_data();
        t_irq();
        t_mode();
        t_unmapped();
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        #1;
        t_reset();
        tally_and_finish();
    end
endmodule

`default_nettype wire
